// ==== rtl/ccb_top.sv ====
// Purpose: Flash boot order, companion reset, status target, mux control
// Assumes: Port events come from on-chip logic on clk_in
// Notes: Pins from outside pass two flops before use, except ec_hold_in, which goes straight into the reset flop
`timescale 1ns/1ns
module ccb_top (
  input wire logic clk_in, // 50 MHz core clock
  input wire logic nrst_in, // Async reset, active low
  input wire ccb_pkg::ccb_evt_t [1:0] port_evt_in, // Per-port events
  input wire logic ec_hold_in, // Embedded controller holds reset
  input wire logic flash_miso_in, // Shared flash data in
  output logic flash_cs_n_out, // Flash select, active low
  output logic flash_sck_out, // Flash clock
  output logic flash_mosi_out, // Flash data out
  output logic flash_oe_out, // High while device owns flash
  output logic companion_reset_line_n_out, // Companion reset, active low
  input wire logic tgt_scl_in, // Target port clock pin
  input wire logic tgt_sda_in, // Target port data pin
  output logic tgt_sda_oe_out, // Pull data low when high
  output logic companion_irq_n_out, // Shared interrupt, active low
  output logic [1:0] sideband_select_a_out, // Per-port select A
  output logic [1:0] sideband_select_b_out, // Per-port select B
  output logic [1:0] aux_path_enable_out, // Per-port aux enable
  output logic [1:0] sideband_link_enable_out, // Per-port link enable
  input wire logic ctl_scl_in, // Controller port clock pin
  input wire logic ctl_sda_in, // Controller port data pin
  output logic ctl_scl_oe_out, // Pull clock low when high
  output logic ctl_sda_oe_out, // Pull data low when high
  output ccb_pkg::ccb_pdo_t src_pdo_out, // Source capability
  output ccb_pkg::ccb_pdo_t [3:0] snk_pdo_out // Sink capabilities
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] stat_byte(input ccb_pkg::ccb_evt_t e);
    stat_byte = {e.conn, e.orient, e.dp_mode, e.companion_mode, e.usb3,
                 3'h0};
  endfunction
  function automatic logic addr_hit(input logic [6:0] a);
    addr_hit = (a == ccb_pkg::ADDR_PORT_A) || (a == ccb_pkg::ADDR_PORT_B);
  endfunction

  // ----------------------------------------------------------------
  // Boot order and shared flash load
  // ----------------------------------------------------------------
  ccb_pkg::ccb_boot_t boot_st, next_boot;
  logic miso_m, miso_s, sck, spi_done, tick_s;
  logic [7:0] sdiv, srx;
  logic [15:0] scnt;
  logic [31:0] stx;
  assign tick_s = sdiv == 8'(ccb_pkg::SPI_HALF_CYC - 1);
  assign spi_done = tick_s && !sck && (scnt == ccb_pkg::SPI_TOTAL_BITS);

  // Boot sequence: hold, load, then hand the flash over
  always_comb begin
    next_boot = boot_st;
    unique case (boot_st)
      ccb_pkg::B_HOLD: next_boot = ccb_pkg::B_LOAD;
      ccb_pkg::B_LOAD: next_boot = spi_done ? ccb_pkg::B_REL : boot_st;
      ccb_pkg::B_REL: next_boot = boot_st;
    endcase
  end

  // Flash data crosses in through two flops
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
      boot_st <= ccb_pkg::B_HOLD;
      sdiv <= 8'h00;
    end else begin
      miso_m <= flash_miso_in;
      miso_s <= miso_m;
      boot_st <= next_boot;
      sdiv <= (boot_st != ccb_pkg::B_LOAD || tick_s) ? 8'h00 : sdiv + 8'h01;
    end
  end

  // exclusive flash load
  // Pins drop to high impedance once done, so no overlap with companion
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sck <= 1'b0;
      scnt <= 16'h0000;
      stx <= {ccb_pkg::FLASH_RD_CMD, ccb_pkg::CFG_BASE};
      srx <= 8'h00;
      flash_oe_out <= 1'b0;
      flash_cs_n_out <= 1'b1;
    end else begin
      flash_oe_out <= next_boot == ccb_pkg::B_LOAD;
      flash_cs_n_out <= next_boot != ccb_pkg::B_LOAD;
      if (boot_st == ccb_pkg::B_LOAD && tick_s) begin
        if (!sck && !spi_done) begin
          sck <= 1'b1;
          srx <= {srx[6:0], miso_s};
        end else if (sck) begin
          sck <= 1'b0;
          scnt <= scnt + 16'h0001;
          stx <= {stx[30:0], 1'b0};
        end
      end
    end
  end

  // Flash pin drive, all from flops
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flash_sck_out <= 1'b0;
      flash_mosi_out <= 1'b0;
    end else begin
      flash_sck_out <= sck;
      flash_mosi_out <= stx[31];
    end
  end

  // ----------------------------------------------------------------
  // Companion reset
  // ----------------------------------------------------------------
  // asserted from power-up
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) companion_reset_line_n_out <= 1'b0;
    else companion_reset_line_n_out <= (boot_st == ccb_pkg::B_REL) &&
                                       !ec_hold_in;
  end

  // ----------------------------------------------------------------
  // Status target port
  // ----------------------------------------------------------------
  ccb_pkg::ccb_tgt_t tst;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic tport, trd;
  logic [3:0] tcnt;
  logic [7:0] tsh, stat_sel;
  logic scl_rise, scl_fall, t_start, t_stop, addr_done;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign t_start = scl_s && scl_d && sda_d && !sda_s;
  assign t_stop = scl_s && scl_d && !sda_d && sda_s;
  assign addr_done = (tst == ccb_pkg::T_ADDR) && scl_fall &&
                     (tcnt == ccb_pkg::I2C_BYTE_BITS);
  assign stat_sel = stat_byte(port_evt_in[tport]);

  // Pin synchronisers and edge history
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {tgt_scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {tgt_sda_in, sda_m, sda_s};
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tst <= ccb_pkg::T_IDLE;
      tcnt <= 4'h0;
      tsh <= 8'h00;
      tport <= 1'b0;
      trd <= 1'b0;
      tgt_sda_oe_out <= 1'b0;
    end else if (t_start) begin
      tst <= ccb_pkg::T_ADDR;
      tcnt <= 4'h0;
      tgt_sda_oe_out <= 1'b0;
    end else if (t_stop) begin
      tst <= ccb_pkg::T_IDLE;
      tgt_sda_oe_out <= 1'b0;
    end else if (scl_rise && (tst == ccb_pkg::T_ADDR ||
                              tst == ccb_pkg::T_RX)) begin
      tsh <= {tsh[6:0], sda_s};
      tcnt <= tcnt + 4'h1;
    end else if (scl_rise && tst == ccb_pkg::T_MACK && sda_s) begin
      tst <= ccb_pkg::T_IDLE; // Reader says no more
    end else if (scl_fall) begin
      unique case (tst)
        ccb_pkg::T_ADDR: if (tcnt == ccb_pkg::I2C_BYTE_BITS) begin
          tst <= addr_hit(tsh[7:1]) ? ccb_pkg::T_ACK : ccb_pkg::T_IDLE;
          tgt_sda_oe_out <= addr_hit(tsh[7:1]);
          tport <= tsh[7:1] == ccb_pkg::ADDR_PORT_B;
          trd <= tsh[0];
        end
        ccb_pkg::T_ACK, ccb_pkg::T_MACK: if (trd) begin
          tst <= ccb_pkg::T_TX;
          tsh <= stat_sel;
          tgt_sda_oe_out <= !stat_sel[7];
          tcnt <= 4'h1;
        end else begin
          tst <= ccb_pkg::T_RX;
          tgt_sda_oe_out <= 1'b0;
          tcnt <= 4'h0;
        end
        ccb_pkg::T_TX: if (tcnt == ccb_pkg::I2C_BYTE_BITS) begin
          tst <= ccb_pkg::T_MACK;
          tgt_sda_oe_out <= 1'b0;
        end else begin
          tsh <= {tsh[6:0], 1'b0};
          tgt_sda_oe_out <= !tsh[6];
          tcnt <= tcnt + 4'h1;
        end
        ccb_pkg::T_RX: if (tcnt == ccb_pkg::I2C_BYTE_BITS) begin
          tst <= ccb_pkg::T_ACK; // Writes are acknowledged, not stored
          tgt_sda_oe_out <= 1'b1;
        end
        ccb_pkg::T_IDLE: tst <= ccb_pkg::T_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shared interrupt and sideband mux
  // ----------------------------------------------------------------
  logic [1:0] pend, conn_d, next_pend;
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      wire conn_rise = port_evt_in[gp].conn && !conn_d[gp];
      wire rd_clr = addr_done && addr_hit(tsh[7:1]) && tsh[0] &&
                    ((tsh[7:1] == ccb_pkg::ADDR_PORT_B) == (gp == 1));
      // connect sets pending
      // A new connection wins over a read that clears in the same cycle
      assign next_pend[gp] = conn_rise || (pend[gp] && !rd_clr);
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          {sideband_select_a_out[gp], sideband_select_b_out[gp]} <= 2'h0;
          aux_path_enable_out[gp] <= 1'b0;
          sideband_link_enable_out[gp] <= 1'b0;
        end else begin
          sideband_select_a_out[gp] <= port_evt_in[gp].orient;
          sideband_select_b_out[gp] <= port_evt_in[gp].orient;
          aux_path_enable_out[gp] <= port_evt_in[gp].dp_mode;
          sideband_link_enable_out[gp] <= port_evt_in[gp].companion_mode;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend <= 2'h0;
      conn_d <= 2'h0;
      companion_irq_n_out <= 1'b1;
    end else begin
      pend <= next_pend;
      conn_d <= {port_evt_in[1].conn, port_evt_in[0].conn};
      companion_irq_n_out <= !(|next_pend);
    end
  end

  // ----------------------------------------------------------------
  // Controller port toward the SoC
  // ----------------------------------------------------------------
  // Write-only, no arbitration or stretching: SoC must not hold clock
  logic mbusy, mreq, mtick, m_go, m_bit, m_scl, m_sda;
  logic [1:0] mq;
  logic [4:0] mslot;
  logic [7:0] mdiv, stat0_d;
  logic [15:0] mbits;
  assign mtick = mdiv == 8'(ccb_pkg::I2CM_QTR_CYC - 1);
  assign m_go = mreq && !mbusy && boot_st == ccb_pkg::B_REL;
  assign m_bit = (mslot <= ccb_pkg::M_SLOT_ADDR_END) ?
                 mbits[4'(5'h10 - mslot)] : mbits[4'(5'h11 - mslot)];
  assign m_scl = (mslot == 5'h00) ? (mq != 2'h3) :
                 (mslot == ccb_pkg::M_SLOT_STOP) ? (mq != 2'h0) :
                 (mq == 2'h1 || mq == 2'h2);
  assign m_sda = (mslot == 5'h00) ? (mq < 2'h2) :
                 (mslot == ccb_pkg::M_SLOT_STOP) ? (mq >= 2'h2) :
                 (mslot == ccb_pkg::M_SLOT_ACK1 ||
                  mslot == ccb_pkg::M_SLOT_ACK2) ? 1'b1 : m_bit;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {mbusy, mreq} <= 2'h0;
      {mq, mslot, mdiv, stat0_d} <= 23'h000000;
      mbits <= 16'h0000;
      {ctl_scl_oe_out, ctl_sda_oe_out} <= 2'h0;
    end else begin
      stat0_d <= stat_byte(port_evt_in[0]);
      mreq <= (stat0_d != stat_byte(port_evt_in[0])) || (mreq && !m_go);
      mdiv <= (!mbusy || mtick) ? 8'h00 : mdiv + 8'h01;
      ctl_scl_oe_out <= mbusy && !m_scl;
      ctl_sda_oe_out <= mbusy && !m_sda;
      if (m_go) begin
        {mbusy, mslot, mq} <= {1'b1, 7'h00};
        mbits <= {ccb_pkg::SOC_ADDR_DEF, 1'b0, stat0_d};
      end else if (mbusy && mtick) begin
        mq <= mq + 2'h1;
        if (mq == 2'h3 && mslot == ccb_pkg::M_SLOT_STOP) mbusy <= 1'b0;
        else if (mq == 2'h3) mslot <= mslot + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Advertised capabilities
  // ----------------------------------------------------------------
  // single source PDO
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_pdo_out <= ccb_pkg::PDO_SRC;
      snk_pdo_out <= ccb_pkg::PDO_SNK;
    end else begin
      src_pdo_out <= ccb_pkg::PDO_SRC;
      snk_pdo_out <= ccb_pkg::PDO_SNK;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_flash_excl: assert property (
    flash_oe_out |-> !companion_reset_line_n_out)
    else $error("companion out of reset while flash owned");
  a_release_after: assert property (
    $fell(flash_oe_out) && !ec_hold_in |->
      !companion_reset_line_n_out ##1 companion_reset_line_n_out)
    else $error("reset not released one cycle after load");
  a_reset_powerup: assert property (
    boot_st != ccb_pkg::B_REL |=> !companion_reset_line_n_out)
    else $error("reset released before boot finished");
  a_ec_hold: assert property (
    ec_hold_in |=> !companion_reset_line_n_out)
    else $error("hold request ignored");
  a_addr_ack: assert property (
    addr_done && addr_hit(tsh[7:1]) |=>
      tgt_sda_oe_out && tst == ccb_pkg::T_ACK)
    else $error("matching address not acknowledged");
  a_port_select: assert property (
    tst == ccb_pkg::T_ACK && scl_fall && trd && !t_start && !t_stop |=>
      tsh == $past(stat_sel))
    else $error("wrong port status loaded");
  a_conn_bit: assert property (
    tst == ccb_pkg::T_TX && $past(tst) != ccb_pkg::T_TX |->
      tgt_sda_oe_out == !$past(stat_sel[7]))
    else $error("connection bit not driven first");
  a_irq_conn: assert property (
    port_evt_in[0].conn && !conn_d[0] |=> !companion_irq_n_out)
    else $error("no interrupt on connection");
  a_mux_follow: assert property (
    ##1 aux_path_enable_out[1] == $past(port_evt_in[1].dp_mode) &&
      sideband_select_b_out[0] == $past(port_evt_in[0].orient))
    else $error("mux control not following events");
  a_ctl_start: assert property (
    mbusy && mslot == 5'h00 && mq == 2'h2 && !mtick |=>
      ctl_sda_oe_out && !ctl_scl_oe_out)
    else $error("start condition malformed");
  a_src_pdo: assert property (
    src_pdo_out.ma10 == 10'h096 && src_pdo_out.mv50 == 10'h064)
    else $error("source PDO changed");
  a_snk_pdo: assert property (
    snk_pdo_out[3].mv50 == 10'h190 && snk_pdo_out[0].ma10 == 10'h12C)
    else $error("sink PDO changed");
  c_release: cover property ($rose(companion_reset_line_n_out));
  c_read_b: cover property (tst == ccb_pkg::T_TX && tport);
  c_irq: cover property ($fell(companion_irq_n_out));
  c_ctl_done: cover property ($fell(mbusy));
endmodule // ccb_top

// ==== common/ccb_pkg.sv ====
// Purpose: Shared constants and types for the companion boot/status block
// Assumes: 50 MHz core clock, one clock domain
// Notes: PDO fields use 50 mV and 10 mA units
package ccb_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned SPI_HALF_NS = 80;
  localparam int unsigned SPI_HALF_CYC = (SPI_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned I2CM_BIT_NS = 10000;
  localparam int unsigned I2CM_QTR_CYC =
    (I2CM_BIT_NS / 4 + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------------
  // Addresses, counts, flash frame
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_PORT_A = 7'h38;
  localparam logic [6:0] ADDR_PORT_B = 7'h3F;
  localparam logic [6:0] SOC_ADDR_DEF = 7'h20;
  localparam logic [7:0] FLASH_RD_CMD = 8'h03;
  localparam logic [23:0] CFG_BASE = 24'h000000;
  localparam logic [15:0] SPI_HDR_BITS = 16'h0020;
  localparam logic [15:0] CFG_BYTES = 16'h0040;
  localparam logic [15:0] SPI_TOTAL_BITS = 16'h0220;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  localparam logic [4:0] M_SLOT_ADDR_END = 5'h08;
  localparam logic [4:0] M_SLOT_ACK1 = 5'h09;
  localparam logic [4:0] M_SLOT_ACK2 = 5'h12;
  localparam logic [4:0] M_SLOT_STOP = 5'h13;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic conn;
    logic orient;
    logic dp_mode;
    logic companion_mode;
    logic usb3;
  } ccb_evt_t;
  typedef struct packed {
    logic [9:0] mv50;
    logic [9:0] ma10;
  } ccb_pdo_t;
  typedef enum logic [2:0] {
    B_HOLD = 3'b001,
    B_LOAD = 3'b010,
    B_REL = 3'b100
  } ccb_boot_t;
  typedef enum logic [5:0] {
    T_IDLE = 6'b000001,
    T_ADDR = 6'b000010,
    T_ACK = 6'b000100,
    T_TX = 6'b001000,
    T_MACK = 6'b010000,
    T_RX = 6'b100000
  } ccb_tgt_t;
  // ----------------------------------------------------------------
  // Advertised power data objects
  // ----------------------------------------------------------------
  localparam ccb_pdo_t PDO_SRC = '{mv50: 10'h064, ma10: 10'h096};
  localparam ccb_pdo_t [3:0] PDO_SNK = {
    ccb_pdo_t'({10'h190, 10'h12C}), ccb_pdo_t'({10'h12C, 10'h12C}),
    ccb_pdo_t'({10'h0B4, 10'h12C}), ccb_pdo_t'({10'h064, 10'h12C})};
endpackage

// ==== verification/ccb_flash_model.sv ====
// Purpose: Shared flash stand-in on the far side of the boot loader
// Assumes: SPI mode 0, a 32-bit command and address header
// Notes: Data byte n is n xor A5; unselected line shows inverted data
`timescale 1ns/1ns
module ccb_flash_model (
  input wire logic cs_n_in, // Select, pulled up when released
  input wire logic sck_in, // Serial clock
  input wire logic mosi_in, // Data from the device
  output logic miso_out, // Data to the device
  output logic [31:0] hdr_out // Command and address seen
);
  // ------------------------------------------------------------
  // Shift logic
  // ------------------------------------------------------------
  int unsigned nbit;
  logic drv;
  logic [7:0] dbyte;
  initial begin
    nbit = 0;
    drv = 1'b0;
    hdr_out = 32'h00000000;
  end
  always @(posedge sck_in) begin
    if (!cs_n_in && nbit < 32) begin
      hdr_out = {hdr_out[30:0], mosi_in};
    end
    if (!cs_n_in) begin
      nbit = nbit + 1;
    end
  end
  // Data launched on the falling edge once the header is in
  always @(negedge sck_in) begin
    if (!cs_n_in && nbit >= 32) begin
      dbyte = 8'((nbit - 32) / 8) ^ 8'hA5;
      drv = dbyte[7 - ((nbit - 32) % 8)];
    end
  end
  assign miso_out = cs_n_in ? ~drv : drv; // Idle line shows the last bit inverted
endmodule // ccb_flash_model

// ==== verification/ccb_top_tb.sv ====
// Purpose: Self-checking bench for boot order, status link and mux pins
// Assumes: 50 MHz clock, target SCL period 160 ns
// Notes: Open-drain lines are resolved here with pull-ups
`timescale 1ns/1ns
module ccb_top_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_in, nrst_in, ec_hold_in, tscl, msda;
  ccb_pkg::ccb_evt_t [1:0] evt;
  logic flash_cs_n_out, flash_sck_out, flash_mosi_out, flash_oe_out;
  logic miso, companion_reset_line_n_out, tgt_sda_oe_out;
  logic companion_irq_n_out, ctl_scl_oe_out, ctl_sda_oe_out;
  logic [1:0] sideband_select_a_out, sideband_select_b_out;
  logic [1:0] aux_path_enable_out, sideband_link_enable_out;
  ccb_pkg::ccb_pdo_t src_pdo_out;
  ccb_pkg::ccb_pdo_t [3:0] snk_pdo_out;
  logic [31:0] hdr;
  logic companion_supply_rail_ok = 1'b0; // Companion supply valid
  // board gate ANDs device reset with companion supply
  wire companion_reset_gated_n = companion_reset_line_n_out &
    companion_supply_rail_ok;
  int mismatches = 0;
  int check_count = 0;
  // Released flash pins fall to their pull levels
  wire flash_cs = ~flash_oe_out | flash_cs_n_out;
  wire flash_sck = flash_oe_out & flash_sck_out;
  wire flash_mosi = flash_oe_out & flash_mosi_out;
  wire tgt_sda = msda & ~tgt_sda_oe_out;
  wire ctl_scl = ~ctl_scl_oe_out;
  wire ctl_sda = ~ctl_sda_oe_out;
  ccb_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .port_evt_in(evt),
    .ec_hold_in(ec_hold_in), .flash_miso_in(miso),
    .flash_cs_n_out(flash_cs_n_out), .flash_sck_out(flash_sck_out),
    .flash_mosi_out(flash_mosi_out), .flash_oe_out(flash_oe_out),
    .companion_reset_line_n_out(companion_reset_line_n_out),
    .tgt_scl_in(tscl), .tgt_sda_in(tgt_sda),
    .tgt_sda_oe_out(tgt_sda_oe_out),
    .companion_irq_n_out(companion_irq_n_out),
    .sideband_select_a_out(sideband_select_a_out),
    .sideband_select_b_out(sideband_select_b_out),
    .aux_path_enable_out(aux_path_enable_out),
    .sideband_link_enable_out(sideband_link_enable_out),
    .ctl_scl_in(ctl_scl), .ctl_sda_in(ctl_sda),
    .ctl_scl_oe_out(ctl_scl_oe_out), .ctl_sda_oe_out(ctl_sda_oe_out),
    .src_pdo_out(src_pdo_out), .snk_pdo_out(snk_pdo_out));
  ccb_flash_model flash (.cs_n_in(flash_cs), .sck_in(flash_sck),
    .mosi_in(flash_mosi), .miso_out(miso), .hdr_out(hdr));
  // ------------------------------------------------------------
  // Controller port monitor: bits on SCL rise after a START
  // ------------------------------------------------------------
  logic pscl = 1'b1;
  logic psda = 1'b1;
  logic [4:0] cidx = 5'h11;
  logic [16:0] cbits = 17'h00000;
  always @(posedge clk_in) begin
    if (pscl && ctl_scl && psda && !ctl_sda) begin
      cidx <= 5'h00;
    end else if (!pscl && ctl_scl && cidx < 5'h11) begin
      cbits[5'h10 - cidx] <= ctl_sda;
      cidx <= cidx + 5'h01;
    end
    pscl <= ctl_scl;
    psda <= ctl_sda;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time,
        seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One SCL period of 8 clocks; line read at the end of high
  task automatic i2c_bit(input logic b, output logic r);
    @(posedge clk_in) tscl <= 1'b0;
    repeat (2) @(posedge clk_in);
    msda <= b;
    repeat (2) @(posedge clk_in);
    tscl <= 1'b1;
    repeat (3) @(posedge clk_in);
    r = tgt_sda;
  endtask
  task automatic i2c_read(input logic [6:0] a, output logic ack,
      output logic [7:0] d);
    logic r;
    logic [7:0] ab;
    ab = {a, 1'b1};
    @(posedge clk_in) msda <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(ab[i], r);
    end
    i2c_bit(1'b1, ack);
    for (int i = 0; i < 8; i++) begin
      i2c_bit(1'b1, r);
      d = {d[6:0], r};
    end
    i2c_bit(1'b1, r);
    i2c_bit(1'b0, r);
    @(posedge clk_in) msda <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_boot();
    int n;
    logic held;
    n = 0;
    held = 1'b1;
    check(companion_reset_line_n_out, 1'b0);
    check(companion_irq_n_out, 1'b1);
    @(posedge clk_in) nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    check(flash_oe_out, 1'b1);
    while (flash_oe_out === 1'b1 && n < 6000) begin
      held = held & (companion_reset_line_n_out === 1'b0);
      n++;
      @(posedge clk_in);
    end
    check(held, 1'b1);
    check(n > 4300 && n < 4450, 1'b1);
    @(posedge clk_in);
    check(companion_reset_line_n_out, 1'b1);
    check(hdr, {8'h03, 24'h000000});
    // Units of 50 mV and 10 mA
    check(src_pdo_out, {10'h064, 10'h096});
    check(snk_pdo_out, {10'h190, 10'h12C, 10'h12C, 10'h12C,
      10'h0B4, 10'h12C, 10'h064, 10'h12C});
  endtask
  // Dead supply first, then the EC holds reset while the rail settles
  task automatic t_hold();
    check(companion_reset_gated_n, 1'b0);
    @(posedge clk_in) ec_hold_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check(companion_reset_line_n_out, 1'b0);
    companion_supply_rail_ok <= 1'b1;
    // 100 us of held reset after the rail is valid
    repeat (5000) @(posedge clk_in);
    check(companion_reset_gated_n, 1'b0);
    @(posedge clk_in) ec_hold_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check(companion_reset_line_n_out, 1'b1);
    check(companion_reset_gated_n, 1'b1);
    check(flash_oe_out, 1'b0);
  endtask
  // One event at a time so a swapped output shows
  task automatic t_mux();
    logic [4:0] v;
    for (int p = 0; p < 2; p++) begin
      for (int k = 1; k < 4; k++) begin
        v = 5'(1 << k);
        @(posedge clk_in) evt[p] <= v;
        repeat (3) @(posedge clk_in);
        check(sideband_select_a_out[p], v[3]);
        check(sideband_select_b_out[p], v[3]);
        check(aux_path_enable_out[p], v[2]);
        check(sideband_link_enable_out[p], v[1]);
      end
    end
  endtask
  task automatic t_irq();
    logic ack;
    logic [7:0] d;
    @(posedge clk_in) evt[1] <= 5'b11001;
    repeat (3) @(posedge clk_in);
    check(companion_irq_n_out, 1'b0);
    // Shared line: both addresses are read
    i2c_read(7'h38, ack, d);
    check(ack, 1'b0);
    check(d, 8'h40);
    check(companion_irq_n_out, 1'b0);
    i2c_read(7'h3F, ack, d);
    check(ack, 1'b0);
    check(d, 8'hC8);
    check(companion_irq_n_out, 1'b1);
    @(posedge clk_in) evt[0] <= 5'b10110;
    repeat (3) @(posedge clk_in);
    check(companion_irq_n_out, 1'b0);
    i2c_read(7'h38, ack, d);
    check(d, 8'hB0);
    check(companion_irq_n_out, 1'b1);
    i2c_read(7'h22, ack, d);
    check(ack, 1'b1);
  endtask
  task automatic t_ctl();
    @(posedge clk_in) evt[0] <= 5'b10101;
    // Earlier changes queue frames of 10000 clocks; let them drain
    repeat (40000) @(posedge clk_in);
    check(cbits[16:9], {7'h20, 1'b0});
    check(cbits[7:0], 8'hA8);
  endtask
  // ------------------------------------------------------------
  // Clock, sequence, watchdog
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    nrst_in = 1'b0;
    ec_hold_in = 1'b0;
    evt = '0;
    tscl = 1'b1;
    msda = 1'b1;
    repeat (5) @(posedge clk_in);
    t_boot();
    t_hold();
    t_mux();
    t_irq();
    t_ctl();
    give_verdict();
  end
  // Whole run is about 50000 clocks
  initial begin
    #1400000;
    mismatches++;
    give_verdict();
  end
endmodule // ccb_top_tb
